// file: design/iop_port_latches.v
// port latches, pin drivers and axi4-lite register slave
`include "iop_consts.vh"

// How it works
// - input-only port sampled on read, no latch
// - high-current port latch, read returns latch
// - reset sets all port latches to ones
// - single-bit port reads pin when latch one
// - upper three single-bit latches still stored
// - analog-shared pins need latch one first
// - analog selector resets to channel zero
// - watchdog reaches pin only with latch one
// - watchdog port bits three, two read one
// - watchdog port bit zero latch without pin
// - interrupt/timer pins need latch one first
// - serial pins need latch one first
// - hold sense reads inverted in bit zero
module iop_port_latches (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [3:0] input_only_port_i,
   output wire [3:0] high_current_out_port_o,
   input wire single_bit_out_port_i,
   output wire single_bit_out_port_o,
   output wire single_bit_out_port_oe,
   input wire [3:0] analog_shared_port_i,
   output wire [3:0] analog_shared_port_o,
   output wire [3:0] analog_shared_port_oe,
   input wire watchdog_shared_port_i,
   output wire watchdog_shared_port_o,
   output wire watchdog_shared_port_oe,
   input wire [2:0] interrupt_timer_shared_port_i,
   output wire [2:0] interrupt_timer_shared_port_o,
   output wire [2:0] interrupt_timer_shared_port_oe,
   input wire [2:0] serial_shared_port_i,
   output wire [2:0] serial_shared_port_o,
   output wire [2:0] serial_shared_port_oe,
   input wire hold_sense_input_i,
   input wire watchdog_output,
   input wire serial_clk_out,
   input wire serial_clk_out_en,
   input wire serial_data_out,
   output wire [1:0] analog_channel_sel,
   output wire ext_interrupt_one,
   output wire ext_interrupt_two,
   output wire timer_two_count_input,
   output wire serial_clk_in,
   output wire serial_data_in,
   output wire hold_request_level
);

   // port latches
   reg [3:0] high_current_r;
   reg [3:0] single_bit_r;
   reg [3:0] analog_r;
   reg [3:0] watchdog_r;
   reg [3:0] int_timer_r;
   reg [3:0] serial_r;
   reg [1:0] analog_sel_r;

   // axi state
   reg aw_held_r;
   reg [7:0] aw_addr_r;
   reg w_held_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg bvalid_r;
   reg [1:0] bresp_r;
   reg rvalid_r;
   reg [31:0] rdata_r;
   reg [1:0] rresp_r;

   wire [`IOP_SYNC_W-1:0] pin_raw;
   wire [`IOP_SYNC_W-1:0] pin_lvl;
   wire [3:0] lvl_input_only;
   wire lvl_single_bit;
   wire [3:0] lvl_analog;
   wire lvl_watchdog;
   wire [2:0] lvl_int_timer;
   wire [2:0] lvl_serial;
   wire lvl_hold;

   wire aw_fire;
   wire w_fire;
   wire ar_fire;
   wire do_write;
   wire [7:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire [3:0] wr_idx;
   wire [3:0] rd_idx;
   reg [3:0] rd_val;
   wire [3:0] wr_nib;
   wire wr_lane0;

   // shared between read and write paths
   function [3:0] iop_decode;
      input [7:0] addr;
      begin
         case (addr)
            `IOP_OFS_INPUT_ONLY: iop_decode = `IOP_IDX_INPUT_ONLY;
            `IOP_OFS_HIGH_CURRENT: iop_decode = `IOP_IDX_HIGH_CURRENT;
            `IOP_OFS_SINGLE_BIT: iop_decode = `IOP_IDX_SINGLE_BIT;
            `IOP_OFS_ANALOG: iop_decode = `IOP_IDX_ANALOG;
            `IOP_OFS_WATCHDOG: iop_decode = `IOP_IDX_WATCHDOG;
            `IOP_OFS_INT_TIMER: iop_decode = `IOP_IDX_INT_TIMER;
            `IOP_OFS_SERIAL: iop_decode = `IOP_IDX_SERIAL;
            `IOP_OFS_HOLD_SENSE: iop_decode = `IOP_IDX_HOLD_SENSE;
            `IOP_OFS_ANALOG_SEL: iop_decode = `IOP_IDX_ANALOG_SEL;
            default: iop_decode = `IOP_IDX_NONE;
         endcase
      end
   endfunction

   // open-drain style pin: low when either source asks for zero
   function iop_pull_low;
      input latch_bit;
      input periph_bit;
      begin
         iop_pull_low = ~(latch_bit & periph_bit);
      end
   endfunction

   assign pin_raw = {hold_sense_input_i, serial_shared_port_i,
                     interrupt_timer_shared_port_i, watchdog_shared_port_i,
                     analog_shared_port_i, single_bit_out_port_i,
                     input_only_port_i};

   // idle pins float high on the board, so start as ones
   iop_pin_sync #(
      .WIDTH(`IOP_SYNC_W),
      .INIT({`IOP_SYNC_W{1'b1}})
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(pin_raw),
      .level(pin_lvl)
   );

   assign lvl_input_only = pin_lvl[`IOP_POS_INPUT_ONLY +: 4];
   assign lvl_single_bit = pin_lvl[`IOP_POS_SINGLE_BIT];
   assign lvl_analog = pin_lvl[`IOP_POS_ANALOG +: 4];
   assign lvl_watchdog = pin_lvl[`IOP_POS_WATCHDOG];
   assign lvl_int_timer = pin_lvl[`IOP_POS_INT_TIMER +: 3];
   assign lvl_serial = pin_lvl[`IOP_POS_SERIAL +: 3];
   assign lvl_hold = pin_lvl[`IOP_POS_HOLD];

   // ---- axi4-lite write channel ----
   assign s_axi_awready = ~aw_held_r & ~bvalid_r;
   assign s_axi_wready = ~w_held_r & ~bvalid_r;
   assign aw_fire = s_axi_awvalid & s_axi_awready;
   assign w_fire = s_axi_wvalid & s_axi_wready;
   assign do_write = (aw_held_r | aw_fire) & (w_held_r | w_fire) & ~bvalid_r;
   assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
   assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
   assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
   assign wr_idx = iop_decode(wr_addr);
   assign wr_nib = wr_data[3:0];
   // port data sits in byte lane zero only
   assign wr_lane0 = do_write & wr_strb[0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_held_r <= 1'b0;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= `IOP_RESP_OKAY;
      end else begin
         if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b1;
            if (wr_idx == `IOP_IDX_NONE) begin
               bresp_r <= `IOP_RESP_SLVERR;
            end else begin
               bresp_r <= `IOP_RESP_OKAY;
            end
         end else begin
            if (aw_fire) begin
               aw_held_r <= 1'b1;
               aw_addr_r <= s_axi_awaddr;
            end
            if (w_fire) begin
               w_held_r <= 1'b1;
               w_data_r <= s_axi_wdata;
               w_strb_r <= s_axi_wstrb;
            end
            if (bvalid_r && s_axi_bready) begin
               bvalid_r <= 1'b0;
            end
         end
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // ---- port latches ----
   always @(posedge aclk) begin
      if (!aresetn) begin
         high_current_r <= `IOP_RST_LATCH4;
         single_bit_r <= `IOP_RST_LATCH4;
         analog_r <= `IOP_RST_LATCH4;
         watchdog_r <= `IOP_RST_LATCH4;
         int_timer_r <= `IOP_RST_LATCH4;
         serial_r <= `IOP_RST_LATCH4;
         analog_sel_r <= `IOP_RST_ANALOG_SEL;
      end else if (wr_lane0) begin
         case (wr_idx)
            `IOP_IDX_HIGH_CURRENT: high_current_r <= wr_nib;
            `IOP_IDX_SINGLE_BIT: single_bit_r <= wr_nib;
            `IOP_IDX_ANALOG: analog_r <= wr_nib;
            `IOP_IDX_WATCHDOG: watchdog_r <= wr_nib;
            `IOP_IDX_INT_TIMER: int_timer_r <= wr_nib;
            `IOP_IDX_SERIAL: serial_r <= wr_nib;
            `IOP_IDX_ANALOG_SEL: analog_sel_r <= wr_nib[1:0];
            default: analog_sel_r <= analog_sel_r;
         endcase
      end
   end

   // ---- read values ----
   assign rd_idx = iop_decode(s_axi_araddr);

   always @* begin
      case (rd_idx)
         `IOP_IDX_INPUT_ONLY: rd_val = lvl_input_only;
         `IOP_IDX_HIGH_CURRENT: rd_val = high_current_r;
         `IOP_IDX_SINGLE_BIT: rd_val = {single_bit_r[3:1], lvl_single_bit};
         `IOP_IDX_ANALOG: rd_val = lvl_analog;
         `IOP_IDX_WATCHDOG: rd_val = {2'b11, lvl_watchdog, watchdog_r[0]};
         // pin-less bit three reads its latch
         `IOP_IDX_INT_TIMER: rd_val = {int_timer_r[3], lvl_int_timer};
         `IOP_IDX_SERIAL: rd_val = {1'b0, lvl_serial};
         `IOP_IDX_HOLD_SENSE: rd_val = {3'b000, ~lvl_hold};
         `IOP_IDX_ANALOG_SEL: rd_val = {2'b00, analog_sel_r};
         default: rd_val = 4'h0;
      endcase
   end

   // ---- axi4-lite read channel ----
   assign s_axi_arready = ~rvalid_r;
   assign ar_fire = s_axi_arvalid & s_axi_arready;

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= `IOP_RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_r <= 1'b1;
         rdata_r <= {28'h0000000, rd_val};
         if (rd_idx == `IOP_IDX_NONE) begin
            rresp_r <= `IOP_RESP_SLVERR;
         end else begin
            rresp_r <= `IOP_RESP_OKAY;
         end
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // ---- pin drivers ----
   assign high_current_out_port_o = high_current_r;

   // open-drain pins only ever drive low
   assign single_bit_out_port_o = 1'b0;
   assign single_bit_out_port_oe = ~single_bit_r[0];

   assign analog_shared_port_o = 4'h0;
   assign analog_shared_port_oe = ~analog_r;

   assign watchdog_shared_port_o = 1'b0;
   assign watchdog_shared_port_oe =
      iop_pull_low(watchdog_r[`IOP_BIT_WDOG_PIN], watchdog_output);

   assign interrupt_timer_shared_port_o = 3'h0;
   assign interrupt_timer_shared_port_oe = ~int_timer_r[2:0];

   assign serial_shared_port_o = 3'h0;
   // clock and data out combined with latch
   assign serial_shared_port_oe[`IOP_BIT_SER_CLK] =
      iop_pull_low(serial_r[`IOP_BIT_SER_CLK], serial_clk_out | ~serial_clk_out_en);
   assign serial_shared_port_oe[`IOP_BIT_SER_OUT] =
      iop_pull_low(serial_r[`IOP_BIT_SER_OUT], serial_data_out);
   assign serial_shared_port_oe[`IOP_BIT_SER_IN] = ~serial_r[`IOP_BIT_SER_IN];

   // ---- levels handed to peripherals ----
   // no conversion guard here, software keeps off ports meanwhile
   assign analog_channel_sel = analog_sel_r;
   assign ext_interrupt_one = lvl_int_timer[2];
   assign timer_two_count_input = lvl_int_timer[1];
   assign ext_interrupt_two = lvl_int_timer[0];
   assign serial_clk_in = lvl_serial[`IOP_BIT_SER_CLK];
   assign serial_data_in = lvl_serial[`IOP_BIT_SER_IN];
   assign hold_request_level = lvl_hold;

endmodule

// file: design/iop_consts.vh
// constants for the microcontroller port latch block
`ifndef IOP_CONSTS_VH
`define IOP_CONSTS_VH

// register byte offsets
`define IOP_OFS_INPUT_ONLY 8'h00
`define IOP_OFS_HIGH_CURRENT 8'h04
`define IOP_OFS_SINGLE_BIT 8'h08
`define IOP_OFS_ANALOG 8'h0C
`define IOP_OFS_WATCHDOG 8'h10
`define IOP_OFS_INT_TIMER 8'h14
`define IOP_OFS_SERIAL 8'h18
`define IOP_OFS_HOLD_SENSE 8'h1C
`define IOP_OFS_ANALOG_SEL 8'h20

// register index codes returned by the decoder
`define IOP_IDX_NONE 4'h0
`define IOP_IDX_INPUT_ONLY 4'h1
`define IOP_IDX_HIGH_CURRENT 4'h2
`define IOP_IDX_SINGLE_BIT 4'h3
`define IOP_IDX_ANALOG 4'h4
`define IOP_IDX_WATCHDOG 4'h5
`define IOP_IDX_INT_TIMER 4'h6
`define IOP_IDX_SERIAL 4'h7
`define IOP_IDX_HOLD_SENSE 4'h8
`define IOP_IDX_ANALOG_SEL 4'h9

// reset values
`define IOP_RST_LATCH4 4'hF
`define IOP_RST_ANALOG_SEL 2'h0

// field positions in the synchronised pin vector
`define IOP_SYNC_W 17
`define IOP_POS_INPUT_ONLY 0
`define IOP_POS_SINGLE_BIT 4
`define IOP_POS_ANALOG 5
`define IOP_POS_WATCHDOG 9
`define IOP_POS_INT_TIMER 10
`define IOP_POS_SERIAL 13
`define IOP_POS_HOLD 16

// field positions inside the four-bit port words
`define IOP_BIT_WDOG_PIN 1
`define IOP_BIT_SER_CLK 2
`define IOP_BIT_SER_OUT 1
`define IOP_BIT_SER_IN 0

// axi responses
`define IOP_RESP_OKAY 2'h0
`define IOP_RESP_SLVERR 2'h2

`endif

// file: design/iop_pin_sync.v
// three-stage pin synchroniser with agreement filter
module iop_pin_sync #(
   parameter WIDTH = 17,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
   input wire aclk,
   input wire aresetn,
   input wire [WIDTH-1:0] pin_in,
   output wire [WIDTH-1:0] level
);

   reg [WIDTH-1:0] st1_r;
   reg [WIDTH-1:0] st2_r;
   reg [WIDTH-1:0] st3_r;
   reg [WIDTH-1:0] level_r;
   reg [WIDTH-1:0] level_nxt;
   integer i;

   // a bit only moves once stages two and three agree
   always @* begin
      level_nxt = level_r;
      for (i = 0; i < WIDTH; i = i + 1) begin
         if (st2_r[i] == st3_r[i]) begin
            level_nxt[i] = st3_r[i];
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         st1_r <= INIT;
         st2_r <= INIT;
         st3_r <= INIT;
         level_r <= INIT;
      end else begin
         st1_r <= pin_in;
         st2_r <= st1_r;
         st3_r <= st2_r;
         level_r <= level_nxt;
      end
   end

   assign level = level_r;

endmodule

// file: verification/iop_port_latches_chk.sv
// assertion checker bound to the port latch block
module iop_port_latches_chk (
   input logic aclk,
   input logic aresetn,
   input logic [7:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic [3:0] high_current_out_port_o,
   input logic single_bit_out_port_o,
   input logic single_bit_out_port_oe,
   input logic [3:0] analog_shared_port_o,
   input logic [3:0] analog_shared_port_oe,
   input logic watchdog_output,
   input logic watchdog_shared_port_oe,
   input logic serial_data_out,
   input logic [2:0] serial_shared_port_oe,
   input logic [1:0] analog_channel_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_take;
   // only joint address and data takes are tracked
   assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_wstrb[0];
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_AN_OE: assert property (wr_take && s_axi_awaddr == 8'h0C |=>
      analog_shared_port_oe == ~$past(s_axi_wdata[3:0]))
      else $error("analog pin drive does not follow latch");
   AST_HC_OUT: assert property (wr_take && s_axi_awaddr == 8'h04 |=>
      high_current_out_port_o == $past(s_axi_wdata[3:0]))
      else $error("high current port not loaded");
   AST_SB_OE: assert property (wr_take && s_axi_awaddr == 8'h08 |=>
      single_bit_out_port_oe == !$past(s_axi_wdata[0]))
      else $error("single bit pin drive does not follow latch");
   AST_WD_LOW: assert property (!watchdog_output |-> watchdog_shared_port_oe)
      else $error("watchdog low not driven");
   AST_SER_LOW: assert property (!serial_data_out |-> serial_shared_port_oe[1])
      else $error("serial data low not driven");
   AST_OPEN_DRAIN: assert property (single_bit_out_port_o == 1'h0
      && analog_shared_port_o == 4'h0)
      else $error("open drain output drives high");
   AST_RST_VAL: assert property ($rose(aresetn) |->
      high_current_out_port_o == 4'hF && analog_channel_sel == 2'h0)
      else $error("wrong value after reset");
   AST_B_ANS: assert property (wr_take |=> s_axi_bvalid)
      else $error("write response late");
   AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_B_REF: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
endmodule

bind iop_port_latches iop_port_latches_chk i_chk (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .high_current_out_port_o, .single_bit_out_port_o, .single_bit_out_port_oe,
   .analog_shared_port_o,
   .analog_shared_port_oe, .watchdog_output, .watchdog_shared_port_oe,
   .serial_data_out, .serial_shared_port_oe, .analog_channel_sel);

// file: verification/iop_board.sv
// board model: pulled-up open drain pins with outside drivers
module iop_board (
   input logic [11:0] oe,
   input logic [11:0] ext_low,
   output logic [11:0] pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // outside level seen only when latch releases pin
   assign pin = ~(oe | ext_low);
endmodule

// file: verification/iop_port_latches_tb_top.sv
// directed testbench for the port latch block
module iop_port_latches_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
   logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF, input_only_port_i = 4'h0;
   logic hold_sense_input_i = 1'h0, watchdog_output = 1'h1, serial_clk_out = 1'h1;
   logic serial_clk_out_en = 1'h0, serial_data_out = 1'h1;
   logic [11:0] ext_low = 12'h000;
   wire [11:0] pin;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp, analog_channel_sel;
   wire [31:0] s_axi_rdata;
   wire [3:0] high_current_out_port_o, analog_shared_port_i, analog_shared_port_o;
   wire [3:0] analog_shared_port_oe;
   wire single_bit_out_port_i, single_bit_out_port_o, single_bit_out_port_oe;
   wire watchdog_shared_port_i, watchdog_shared_port_o, watchdog_shared_port_oe;
   wire [2:0] interrupt_timer_shared_port_i, interrupt_timer_shared_port_o;
   wire [2:0] interrupt_timer_shared_port_oe, serial_shared_port_i;
   wire [2:0] serial_shared_port_o, serial_shared_port_oe;
   wire ext_interrupt_one, ext_interrupt_two, timer_two_count_input;
   wire serial_clk_in, serial_data_in, hold_request_level;
   int fails = 0, n_tests = 0;

   iop_port_latches i_iop_port_latches (.*);
   iop_board i_iop_board (.oe({serial_shared_port_oe, interrupt_timer_shared_port_oe,
      watchdog_shared_port_oe, analog_shared_port_oe, single_bit_out_port_oe}),
      .ext_low(ext_low), .pin(pin));
   assign {serial_shared_port_i, interrupt_timer_shared_port_i, watchdog_shared_port_i,
      analog_shared_port_i, single_bit_out_port_i} = pin;

   always #25 aclk = ~aclk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // bready stays high, so the response is taken where bvalid is seen
   task automatic wr(input logic [7:0] a, input logic [3:0] d, input logic [1:0] rs);
      logic pa, pw;
      pa = 1'h1;
      pw = 1'h1;
      s_axi_awaddr <= a;
      s_axi_wdata <= {28'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (pa && s_axi_awready) begin
            pa = 1'h0;
            s_axi_awvalid <= 1'h0;
         end
         if (pw && s_axi_wready) begin
            pw = 1'h0;
            s_axi_wvalid <= 1'h0;
         end
      end while (!s_axi_bvalid);
      chk({30'h0, s_axi_bresp}, {30'h0, rs});
   endtask

   task automatic rd(input logic [7:0] a, input logic [3:0] e, input logic [1:0] rs);
      logic pr;
      pr = 1'h1;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (pr && s_axi_arready) begin
            pr = 1'h0;
            s_axi_arvalid <= 1'h0;
         end
      end while (!s_axi_rvalid);
      chk(s_axi_rdata, {28'h0, e});
      chk({30'h0, s_axi_rresp}, {30'h0, rs});
   endtask

   task automatic summarize;
      if (fails == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (4000) @(posedge aclk);
      fails++;
      summarize;
   end

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      // let the pin synchroniser settle before reading pins
      cyc(8);
      rd(8'h04, 4'hF, 2'h0);
      rd(8'h08, 4'hF, 2'h0);
      rd(8'h0C, 4'hF, 2'h0);
      rd(8'h10, 4'hF, 2'h0);
      rd(8'h14, 4'hF, 2'h0);
      rd(8'h18, 4'h7, 2'h0);
      rd(8'h20, 4'h0, 2'h0);
      chk({30'h0, analog_channel_sel}, 32'h0);
      rd(8'h1C, 4'h1, 2'h0);
      input_only_port_i <= 4'hA;
      cyc(8);
      rd(8'h00, 4'hA, 2'h0);
      input_only_port_i <= 4'h5;
      cyc(8);
      rd(8'h00, 4'h5, 2'h0);
      wr(8'h04, 4'h3, 2'h0);
      chk({28'h0, high_current_out_port_o}, 32'h3);
      rd(8'h04, 4'h3, 2'h0);
      // lane zero off: latch must keep its value
      s_axi_wstrb <= 4'hE;
      wr(8'h04, 4'h0, 2'h0);
      s_axi_wstrb <= 4'hF;
      chk({28'h0, high_current_out_port_o}, 32'h3);
      wr(8'h08, 4'hA, 2'h0);
      chk({31'h0, single_bit_out_port_oe}, 32'h1);
      cyc(8);
      rd(8'h08, 4'hA, 2'h0);
      wr(8'h08, 4'h5, 2'h0);
      ext_low[0] <= 1'h1;
      cyc(8);
      rd(8'h08, 4'h4, 2'h0);
      ext_low[0] <= 1'h0;
      wr(8'h0C, 4'h0, 2'h0);
      chk({28'h0, analog_shared_port_oe}, 32'hF);
      cyc(8);
      rd(8'h0C, 4'h0, 2'h0);
      wr(8'h0C, 4'hF, 2'h0);
      ext_low[4:1] <= 4'h6;
      cyc(8);
      rd(8'h0C, 4'h9, 2'h0);
      ext_low[4:1] <= 4'h0;
      wr(8'h20, 4'h2, 2'h0);
      chk({30'h0, analog_channel_sel}, 32'h2);
      rd(8'h20, 4'h2, 2'h0);
      wr(8'h10, 4'hC, 2'h0);
      cyc(8);
      chk({31'h0, watchdog_shared_port_oe}, 32'h1);
      rd(8'h10, 4'hC, 2'h0);
      wr(8'h10, 4'h2, 2'h0);
      watchdog_output <= 1'h0;
      cyc(8);
      chk({31'h0, watchdog_shared_port_oe}, 32'h1);
      rd(8'h10, 4'hC, 2'h0);
      watchdog_output <= 1'h1;
      cyc(8);
      rd(8'h10, 4'hE, 2'h0);
      for (int i = 0; i < 3; i++) begin
         ext_low[8:6] <= 3'(1 << i);
         cyc(8);
         chk({29'h0, ext_interrupt_one, timer_two_count_input, ext_interrupt_two},
            {29'h0, ~3'(1 << i)});
         rd(8'h14, {1'h1, ~3'(1 << i)}, 2'h0);
      end
      ext_low[8:6] <= 3'h0;
      wr(8'h14, 4'h5, 2'h0);
      cyc(8);
      chk({31'h0, timer_two_count_input}, 32'h0);
      rd(8'h14, 4'h5, 2'h0);
      serial_data_out <= 1'h0;
      serial_clk_out_en <= 1'h1;
      serial_clk_out <= 1'h0;
      cyc(8);
      chk({29'h0, serial_shared_port_oe}, 32'h6);
      chk({30'h0, serial_clk_in, serial_data_in}, 32'h1);
      rd(8'h18, 4'h1, 2'h0);
      ext_low[9] <= 1'h1;
      serial_data_out <= 1'h1;
      serial_clk_out <= 1'h1;
      cyc(8);
      chk({30'h0, serial_clk_in, serial_data_in}, 32'h2);
      hold_sense_input_i <= 1'h1;
      cyc(8);
      rd(8'h1C, 4'h0, 2'h0);
      chk({31'h0, hold_request_level}, 32'h1);
      // unmapped place answers with an error and no data
      wr(8'h30, 4'h0, 2'h2);
      rd(8'h30, 4'h0, 2'h2);
      summarize;
   end
endmodule
